// file: rtl/usb_ep_regs.vh
// Register map, field positions and reset values of the endpoint block.
`ifndef USB_EP_REGS_VH
`define USB_EP_REGS_VH
// ****************************************************************
// Register addresses
// ****************************************************************
`define ADDR_MODULE_CONTROL 8'hec
`define ADDR_EP0_STATUS 8'hed
`define ADDR_ENDPOINT_SELECT 8'hef
`define ADDR_ENDPOINT_CONTROL 8'hf1
`define ADDR_FIFO_BYTE_COUNT 8'hf2
// ****************************************************************
// Field positions
// ****************************************************************
`define SEL_DIR_BIT 7
`define SEL_EP_HI 2
`define SEL_EP_LO 0
`define CTL_ENABLE_BIT 3
`define CTL_STALL_BIT 2
`define CTL_TOGGLE_BIT 1
`define CTL_BUSY_BIT 0
`define MOD_ENABLE_BIT 2
`define MOD_VISIBLE_BIT 1
`define MOD_WRITE_MASK 8'h07
`define STA_RECEIVED_TOGGLE_BIT 3
`define STA_SETUP_BIT 2
`define STA_IN_BIT 1
`define STA_OUT_BIT 0
`define COUNT_HI 6
`define WIN_LOW_BITS 6
// ****************************************************************
// Reset values
// ****************************************************************
`define SELECT_RESET 8'h00
`define CONTROL_RESET 8'h08
`define MODULE_RESET 8'h00
`define STATUS_RESET 8'h00
`define COUNT_RESET 7'h00
`endif

// file: rtl/endpoint_state.v
// Per-endpoint, per-direction enable, stall, toggle, busy and byte count.
`timescale 1ns/100ps
module endpoint_state #(
    parameter IS_OUT = 0,
    parameter REV_B = 1
) (
    input wire core_clk,
    input wire rst,
    input wire selected,
    input wire ctl_write,
    input wire [7:0] ctl_wdata,
    input wire count_write,
    input wire [6:0] count_wdata,
    input wire module_restart,
    input wire tok_hit,
    input wire ack_in,
    input wire out_start,
    input wire out_good,
    input wire [1:0] out_pid,
    input wire [6:0] out_count,
    output reg enable_reg,
    output reg stall_reg,
    output reg toggle_reg,
    output reg busy_reg,
    output reg [6:0] count_reg,
    output wire retransmit
);
`include "usb_ep_regs.vh"
    localparam [7:0] CTL_RESET_VALUE = `CONTROL_RESET;
    wire fw_ctl;
    wire fw_cnt;
    assign fw_ctl = selected & ctl_write;
    assign fw_cnt = selected & count_write;
    assign retransmit = out_good & (out_pid[0] != toggle_reg);
    always @(posedge core_clk) begin
        if (rst) begin
            enable_reg <= CTL_RESET_VALUE[`CTL_ENABLE_BIT];
            stall_reg <= 1'b0;
            toggle_reg <= 1'b0;
            busy_reg <= 1'b0;
            count_reg <= `COUNT_RESET;
        end else begin
            if (fw_ctl) begin
                enable_reg <= ctl_wdata[`CTL_ENABLE_BIT];
                stall_reg <= ctl_wdata[`CTL_STALL_BIT];
            end
            if (module_restart) begin
                toggle_reg <= 1'b0;
            end else if (REV_B != 0 && fw_ctl && !enable_reg &&
                         ctl_wdata[`CTL_ENABLE_BIT]) begin
                toggle_reg <= 1'b0;
            end else if (IS_OUT == 0 && tok_hit && ack_in) begin
                toggle_reg <= ~toggle_reg;
            // toggle on good OUT; retransmit keeps toggle
            end else if (IS_OUT != 0 && tok_hit && out_good &&
                         !retransmit) begin
                toggle_reg <= ~toggle_reg;
            end
            if (IS_OUT == 0) begin
                if (fw_cnt) begin
                    busy_reg <= 1'b1;
                    count_reg <= count_wdata;
                end else if (tok_hit && ack_in) begin
                    busy_reg <= 1'b0;
                end
            end else begin
                if (tok_hit && out_start) begin
                    busy_reg <= 1'b1;
                end else if (tok_hit && out_good) begin
                    busy_reg <= 1'b0;
                    if (!retransmit) begin
                        count_reg <= out_count;
                    end
                end
            end
        end
    end
endmodule // endpoint_state

// file: rtl/usb_endpoint_select_control.v
// Endpoint select, endpoint control and shared FIFO window steering.
//
// Operation
// - Module enable off-on clears received toggle, IN, OUT endpoint 0 flags.
// - All endpoints share one FIFO window and control/count addresses.
// - FIFO window accesses reach the selected endpoint and direction.
// - Endpoint control accesses act on the selected endpoint and direction.
// - Select bit 7 picks direction, 0 IN, 1 OUT; bits 6..3 reserved.
// - Select bits 2..0 pick endpoint 0 to 4; register resets to zero.
// - Control bit 3 enables the FIFO; all FIFOs reset enabled, 08h.
// - Stall bit set makes every token to that endpoint and direction get STALL.
// - IN toggle picks DATA0/DATA1; flips only on received host ACK.
// - OUT toggle holds expected PID; flips only on good OUT packet.
// - Unexpected OUT toggle: send ACK, no interrupt, toggle kept.
// - Module enable off-on clears toggles of all endpoints both ways.
// - FIFO enable clear then set clears the selected toggle only.
// - IN busy sets on byte count write, clears when the host ACKs the data.
// - OUT busy set while receiving, cleared when transaction completes.
// - Module enable clear ignores tokens; bus reset leaves it alone.
// - Byte count holds IN load or OUT received count of selection.
// - FIFOs appear in one 64-byte window with base low bits zero.
`timescale 1ns/100ps
module usb_endpoint_select_control #(
    parameter NUM_EP = 5,
    parameter EP_BITS = 3,
    parameter REV_B = 1
) (
    input wire core_clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire [15:0] win_base,
    input wire [15:0] xd_addr,
    input wire xd_valid,
    output reg win_hit,
    output reg win_dir,
    output reg [EP_BITS-1:0] win_ep,
    output reg [5:0] win_offset,
    input wire tok_valid,
    input wire [EP_BITS-1:0] tok_ep,
    input wire tok_is_out,
    input wire tok_is_setup,
    input wire tok_ack_in,
    input wire tok_out_start,
    input wire tok_out_good,
    input wire [1:0] tok_out_pid,
    input wire [6:0] tok_out_count,
    input wire usb_bus_reset,
    output reg tok_accept,
    output reg tok_stall,
    output reg tok_out_event,
    output reg usb_module_enable,
    output reg [7:0] endpoint0_status_out
);
`include "usb_ep_regs.vh"
    // ****************************************************************
    // Decoding
    // ****************************************************************
    function is_addr;
        input [7:0] a;
        input [7:0] target;
        begin
            is_addr = (a == target);
        end
    endfunction

    // Reserved bits are never stored, so they always read as zero.
    function [7:0] pack_control;
        input en;
        input st;
        input tg;
        input bs;
        begin
            pack_control = 8'h00;
            pack_control[`CTL_ENABLE_BIT] = en;
            pack_control[`CTL_STALL_BIT] = st;
            pack_control[`CTL_TOGGLE_BIT] = tg;
            pack_control[`CTL_BUSY_BIT] = bs;
        end
    endfunction

    function [7:0] pack_status;
        input received_toggle;
        input setup;
        input in_flag;
        input out_flag;
        begin
            pack_status = `STATUS_RESET;
            pack_status[`STA_RECEIVED_TOGGLE_BIT] = received_toggle;
            pack_status[`STA_SETUP_BIT] = setup;
            pack_status[`STA_IN_BIT] = in_flag;
            pack_status[`STA_OUT_BIT] = out_flag;
        end
    endfunction

    // Slot index is {endpoint, direction}, so each endpoint owns two slots.
    localparam SLOTS = 2 * NUM_EP;
    localparam CNT_W = `COUNT_HI + 1;

    reg [7:0] endpoint_select_reg;
    reg [7:0] module_control_reg;
    reg enable_seen_off_reg;
    reg received_toggle_reg;
    reg ep0_setup_reg;
    reg ep0_in_reg;
    reg ep0_out_reg;
    reg [7:0] rdata_next;
    wire sel_dir;
    wire [EP_BITS-1:0] sel_ep;
    wire wr_sel;
    wire wr_ctl;
    wire wr_cnt;
    wire wr_mod;
    wire restart;
    wire mod_next;
    wire tok_live;
    wire [2*NUM_EP-1:0] en_v;
    wire [2*NUM_EP-1:0] st_v;
    wire [2*NUM_EP-1:0] tg_v;
    wire [2*NUM_EP-1:0] bs_v;
    wire [2*NUM_EP-1:0] rt_v;
    wire [7*2*NUM_EP-1:0] cnt_v;
    wire [3:0] sel_idx;
    wire [3:0] tok_idx;
    wire sel_ok;
    wire tok_ok;
    wire [SLOTS-1:0] sel_hot;
    wire [SLOTS-1:0] tok_hot;

    assign sel_dir = endpoint_select_reg[`SEL_DIR_BIT];
    assign sel_ep = endpoint_select_reg[`SEL_EP_HI:`SEL_EP_LO];
    assign sel_ok = (sel_ep < NUM_EP);
    assign tok_ok = (tok_ep < NUM_EP);
    assign sel_idx = {sel_ep, sel_dir};
    assign tok_idx = {tok_ep, tok_is_out};
    assign wr_sel = reg_wr & is_addr(reg_addr, `ADDR_ENDPOINT_SELECT);
    assign wr_ctl = reg_wr & is_addr(reg_addr, `ADDR_ENDPOINT_CONTROL);
    assign wr_cnt = reg_wr & is_addr(reg_addr, `ADDR_FIFO_BYTE_COUNT);
    assign wr_mod = reg_wr & is_addr(reg_addr, `ADDR_MODULE_CONTROL);
    assign mod_next = reg_wdata[`MOD_ENABLE_BIT];
    assign restart = wr_mod & mod_next & enable_seen_off_reg;
    assign tok_live = tok_valid & usb_module_enable & tok_ok;

    // ****************************************************************
    // Per-endpoint state
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < SLOTS; g = g + 1) begin : gen_ep
            assign sel_hot[g] = sel_ok && sel_idx == g;
            assign tok_hot[g] = tok_live && tok_idx == g;
            endpoint_state #(
                .IS_OUT(g % 2),
                .REV_B(REV_B)
            ) u_state (
                .core_clk(core_clk),
                .rst(rst),
                .selected(sel_hot[g]),
                .ctl_write(wr_ctl),
                .ctl_wdata(reg_wdata),
                .count_write(wr_cnt),
                .count_wdata(reg_wdata[`COUNT_HI:0]),
                .module_restart(restart),
                .tok_hit(tok_hot[g] && !st_v[g]),
                .ack_in(tok_ack_in),
                .out_start(tok_out_start),
                .out_good(tok_out_good),
                .out_pid(tok_out_pid),
                .out_count(tok_out_count),
                .enable_reg(en_v[g]),
                .stall_reg(st_v[g]),
                .toggle_reg(tg_v[g]),
                .busy_reg(bs_v[g]),
                .count_reg(cnt_v[CNT_W*g +: CNT_W]),
                .retransmit(rt_v[g])
            );
        end
    endgenerate

    // ****************************************************************
    // Registers
    // ****************************************************************
    always @(posedge core_clk) begin
        if (rst) begin
            endpoint_select_reg <= `SELECT_RESET;
            module_control_reg <= `MODULE_RESET;
            usb_module_enable <= 1'b0;
            enable_seen_off_reg <= 1'b0;
        end else begin
            if (wr_sel) begin
                endpoint_select_reg <= {reg_wdata[`SEL_DIR_BIT], 4'h0,
                                        reg_wdata[`SEL_EP_HI:`SEL_EP_LO]};
            end
            if (wr_mod) begin
                module_control_reg <= reg_wdata & `MOD_WRITE_MASK;
                usb_module_enable <= mod_next;
                if (!mod_next) begin
                    enable_seen_off_reg <= 1'b1;
                end else begin
                    enable_seen_off_reg <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // Endpoint 0 status
    // ****************************************************************
    always @(posedge core_clk) begin
        if (rst) begin
            received_toggle_reg <= 1'b0;
            ep0_setup_reg <= 1'b0;
            ep0_in_reg <= 1'b0;
            ep0_out_reg <= 1'b0;
        end else if (restart) begin
            received_toggle_reg <= 1'b0;
            ep0_in_reg <= 1'b0;
            ep0_out_reg <= 1'b0;
        end else if (tok_live && tok_ep == {EP_BITS{1'b0}}) begin
            if (tok_is_setup) begin
                ep0_setup_reg <= 1'b1;
                ep0_in_reg <= 1'b0;
                ep0_out_reg <= 1'b0;
            end else if (tok_is_out) begin
                ep0_in_reg <= 1'b0;
                ep0_out_reg <= 1'b1;
                if (tok_out_good) begin
                    received_toggle_reg <= tok_out_pid[0];
                end
            end else begin
                ep0_in_reg <= 1'b1;
                ep0_out_reg <= 1'b0;
            end
        end else if (wr_mod == 1'b0 && reg_wr &&
                     is_addr(reg_addr, `ADDR_EP0_STATUS) &&
                     !reg_wdata[`STA_SETUP_BIT]) begin
            ep0_setup_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Token answers
    // ****************************************************************
    always @(posedge core_clk) begin
        if (rst) begin
            tok_accept <= 1'b0;
            tok_stall <= 1'b0;
            tok_out_event <= 1'b0;
            endpoint0_status_out <= `STATUS_RESET;
        end else begin
            tok_accept <= tok_live;
            tok_stall <= tok_live & st_v[tok_idx];
            tok_out_event <= tok_live & tok_is_out & tok_out_good &
                             !st_v[tok_idx] & !rt_v[tok_idx];
            endpoint0_status_out <= pack_status(received_toggle_reg,
                                                ep0_setup_reg, ep0_in_reg,
                                                ep0_out_reg);
        end
    end

    // ****************************************************************
    // FIFO window
    // ****************************************************************
    // A selection change steers the very next access; nothing is queued.
    always @(posedge core_clk) begin
        if (rst) begin
            win_hit <= 1'b0;
            win_dir <= 1'b0;
            win_ep <= {EP_BITS{1'b0}};
            win_offset <= {`WIN_LOW_BITS{1'b0}};
        end else begin
            win_hit <= xd_valid & module_control_reg[`MOD_VISIBLE_BIT] &
                       sel_ok & en_v[sel_idx] &
                       (xd_addr[15:`WIN_LOW_BITS] ==
                        win_base[15:`WIN_LOW_BITS]);
            win_dir <= sel_dir;
            win_ep <= sel_ep;
            win_offset <= xd_addr[`WIN_LOW_BITS-1:0];
        end
    end

    // ****************************************************************
    // Register read
    // ****************************************************************
    // control shows selection
    always @* begin
        rdata_next = 8'h00;
        case (reg_addr)
            `ADDR_ENDPOINT_SELECT: begin
                rdata_next = endpoint_select_reg;
            end
            `ADDR_ENDPOINT_CONTROL: begin
                if (sel_ok) begin
                    rdata_next = pack_control(en_v[sel_idx], st_v[sel_idx],
                                              tg_v[sel_idx], bs_v[sel_idx]);
                end
            end
            `ADDR_FIFO_BYTE_COUNT: begin
                if (sel_ok) begin
                    rdata_next = {1'b0, cnt_v[CNT_W*sel_idx +: CNT_W]};
                end
            end
            `ADDR_MODULE_CONTROL: begin
                rdata_next = module_control_reg;
            end
            `ADDR_EP0_STATUS: begin
                rdata_next = pack_status(received_toggle_reg, ep0_setup_reg,
                                         ep0_in_reg, ep0_out_reg);
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    // Read data is held between reads so a slow CPU can sample it late.
    always @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end
    end
endmodule // usb_endpoint_select_control

// file: tb/usb_ep_monitor.sv
// Port checker for the endpoint select and control block.
`timescale 1ns/100ps
module usb_ep_monitor #(
    parameter EP_BITS = 3
) (
    input wire core_clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire [15:0] win_base,
    input wire [15:0] xd_addr,
    input wire xd_valid,
    input wire win_hit,
    input wire [5:0] win_offset,
    input wire tok_valid,
    input wire [EP_BITS-1:0] tok_ep,
    input wire tok_is_out,
    input wire tok_out_good,
    input wire usb_bus_reset,
    input wire tok_accept,
    input wire tok_stall,
    input wire tok_out_event,
    input wire usb_module_enable
);
    // ****
    // Checks
    // ****
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_accept;
        tok_valid && usb_module_enable && tok_ep < 5 |=> tok_accept;
    endproperty
    a_accept: assert property (p_accept)
        else $error("token was not taken");
    property p_ignore;
        tok_valid && !usb_module_enable
            |=> !tok_accept && !tok_stall && !tok_out_event;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("token answered while disabled");
    property p_quiet;
        !tok_valid |=> !tok_accept && !tok_stall && !tok_out_event;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("token answer without a token");
    property p_event;
        tok_out_event |-> $past(tok_valid) && $past(tok_out_good)
            && $past(tok_is_out) && !tok_stall;
    endproperty
    a_event: assert property (p_event)
        else $error("out event without good packet");
    property p_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_hold: assert property (p_hold)
        else $error("read data moved without a read");
    property p_sel_rsvd;
        reg_rd && reg_addr == 8'hef |=> reg_rdata[6:3] == 4'h0;
    endproperty
    a_sel_rsvd: assert property (p_sel_rsvd)
        else $error("select reserved bits not zero");
    property p_ctl_rsvd;
        reg_rd && reg_addr == 8'hf1 |=> reg_rdata[7:4] == 4'h0;
    endproperty
    a_ctl_rsvd: assert property (p_ctl_rsvd)
        else $error("control reserved bits not zero");
    property p_sel_back;
        reg_wr && reg_addr == 8'hef ##2 reg_rd && reg_addr == 8'hef
            |=> reg_rdata == ($past(reg_wdata, 3) & 8'h87);
    endproperty
    a_sel_back: assert property (p_sel_back)
        else $error("select read back wrong");
    property p_win;
        win_hit |-> $past(xd_valid)
            && $past(xd_addr[15:6]) == $past(win_base[15:6]);
    endproperty
    a_win: assert property (p_win)
        else $error("window hit outside window");
    property p_off;
        xd_valid && xd_addr[15:6] == win_base[15:6]
            |=> win_offset == $past(xd_addr[5:0]);
    endproperty
    a_off: assert property (p_off)
        else $error("window offset wrong");
    property p_bus_reset;
        usb_bus_reset && !reg_wr |=> $stable(usb_module_enable);
    endproperty
    a_bus_reset: assert property (p_bus_reset)
        else $error("bus reset moved module enable");
endmodule // usb_ep_monitor
bind usb_endpoint_select_control usb_ep_monitor #(.EP_BITS(EP_BITS))
    usb_ep_monitor_i (.*);

// file: tb/usb_host_model.sv
// Engine-side model that offers token results to the block.
`timescale 1ns/100ps
module usb_host_model #(
    parameter EP_BITS = 3
) (
    input wire core_clk,
    output wire tok_valid,
    output wire [EP_BITS-1:0] tok_ep,
    output wire tok_is_out,
    output wire tok_is_setup,
    output wire tok_ack_in,
    output wire tok_out_start,
    output wire tok_out_good,
    output wire [1:0] tok_out_pid,
    output wire [6:0] tok_out_count,
    output wire usb_bus_reset
);
    reg valid_reg;
    reg [16:0] held_reg;
    reg [16:0] junk_reg;
    integer seed;
    wire [16:0] q;
    initial begin
        valid_reg = 1'b0;
        held_reg = 17'h00000;
        junk_reg = 17'h00000;
        seed = 32'hd13f;
    end
    // Idle qualifiers carry noise so a stale value is never trusted.
    always @(negedge core_clk) begin
        junk_reg <= 17'($random(seed));
    end
    assign q = valid_reg ? held_reg : junk_reg;
    assign tok_valid = valid_reg;
    assign tok_ep = q[EP_BITS-1:0];
    assign tok_is_out = q[3];
    assign tok_is_setup = q[4];
    assign tok_ack_in = q[5];
    assign tok_out_start = q[6];
    assign tok_out_good = q[7];
    assign tok_out_pid = q[9:8];
    assign tok_out_count = q[16:10];
    assign usb_bus_reset = junk_reg[16];
    task send(input [16:0] t);
        begin
            repeat (junk_reg[1:0]) @(negedge core_clk);
            @(negedge core_clk);
            held_reg = t;
            valid_reg = 1'b1;
            @(negedge core_clk);
            valid_reg = 1'b0;
        end
    endtask
endmodule // usb_host_model

// file: tb/tb_usb_endpoint_select_control.sv
// Self-checking bench for the endpoint select and control block.
`timescale 1ns/100ps
module tb_usb_endpoint_select_control;
    reg core_clk, rst, reg_wr, reg_rd, xd_valid;
    reg [7:0] reg_addr, reg_wdata;
    reg [15:0] win_base, xd_addr;
    wire [7:0] reg_rdata, endpoint0_status_out;
    wire win_hit, win_dir, tok_valid, tok_is_out, tok_is_setup;
    wire tok_ack_in, tok_out_start, tok_out_good, usb_bus_reset;
    wire tok_accept, tok_stall, tok_out_event, usb_module_enable;
    wire [2:0] win_ep, tok_ep;
    wire [5:0] win_offset;
    wire [1:0] tok_out_pid;
    wire [6:0] tok_out_count;
    integer errors, checks, cycles, seed, i;
    reg [7:0] v, s;
    reg [9:0] st;
    reg [6:0] c;
    usb_endpoint_select_control usb_endpoint_select_control_i (.*);
    usb_host_model usb_host_model_i (.*);
    function [7:0] sel(input integer k);
        sel = {k[0], 4'h0, k[3:1]};
    endfunction
    function [7:0] ctl(input en, input sl, input tg, input bs);
        ctl = {4'h0, en, sl, tg, bs};
    endfunction
    function [16:0] tok(input [2:0] e, input [3:0] f, input [6:0] n);
        tok = {n, 2'b00, f[3:1], 1'b0, f[0], e};
    endfunction
    task chk(input string name, input [7:0] seen, input [7:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("Error %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge core_clk);
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(negedge core_clk);
            reg_wr = 1'b0;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(negedge core_clk);
            reg_addr = a;
            reg_rd = 1'b1;
            @(negedge core_clk);
            reg_rd = 1'b0;
            d = reg_rdata;
        end
    endtask
    task rdc(input [7:0] a, input [7:0] e, input string n);
        begin
            rd(a, v);
            chk(n, v, e);
        end
    endtask
    task tk(input [16:0] t, input [2:0] e);
        begin
            usb_host_model_i.send(t);
            chk("token", {5'h0, tok_accept, tok_stall, tok_out_event},
                {5'h0, e});
        end
    endtask
    task summarize;
        begin
            $display("checks %0d errors %0d", checks, errors);
            if (errors == 0 && checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // A hang costs one mismatch and ends the run.
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 4000) begin
            errors = errors + 1;
            summarize;
        end
    end
    initial begin
        seed = 32'hd13f;
        errors = 0;
        checks = 0;
        cycles = 0;
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        xd_valid = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        win_base = 16'h0000;
        xd_addr = 16'h0000;
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        rdc(8'hef, 8'h00, "select");
        rdc(8'he0, 8'h00, "unmapped");
        for (i = 0; i < 10; i = i + 1) begin
            wr(8'hef, sel(i));
            rdc(8'hf1, 8'h08, "control");
            s = $random(seed);
            st[i] = s[2];
            wr(8'hf1, (s & 8'hf4) | 8'h08);
        end
        for (i = 0; i < 10; i = i + 1) begin
            wr(8'hef, sel(i));
            rdc(8'hf1, ctl(1'b1, st[i], 1'b0, 1'b0), "own");
        end
        s = $random(seed);
        wr(8'hef, s);
        rdc(8'hef, s & 8'h87, "select");
        wr(8'hec, 8'h06);
        wr(8'hef, 8'h03);
        wr(8'hf1, 8'h0c);
        tk(tok(3'd3, 4'b0010, 7'd0), 3'b110);
        rdc(8'hf1, 8'h0c, "stalled");
        tk(tok(3'd5, 4'b0010, 7'd0), 3'b000);
        wr(8'hef, 8'h01);
        wr(8'hf1, 8'h08);
        c = s[6:0] | 7'h01;
        wr(8'hf2, {1'b0, c});
        rdc(8'hf1, 8'h09, "busy");
        rdc(8'hf2, {1'b0, c}, "count");
        tk(tok(3'd1, 4'b0000, 7'd0), 3'b100);
        rd(8'hf1, v);
        chk("no ack", {7'h0, v[1]}, 8'h00);
        tk(tok(3'd1, 4'b0010, 7'd0), 3'b100);
        rdc(8'hf1, 8'h0a, "ack");
        wr(8'hef, 8'h82);
        wr(8'hf1, 8'h08);
        tk(tok(3'd2, 4'b0101, 7'd0), 3'b100);
        rdc(8'hf1, 8'h09, "rx busy");
        tk(tok(3'd2, 4'b1001, c), 3'b101);
        rdc(8'hf1, 8'h0a, "rx done");
        rdc(8'hf2, {1'b0, c}, "rx count");
        tk(tok(3'd2, 4'b1001, ~c), 3'b100);
        rdc(8'hf1, 8'h0a, "retry");
        rdc(8'hf2, {1'b0, c}, "retry count");
        wr(8'hef, 8'h01);
        wr(8'hf1, 8'h00);
        wr(8'hf1, 8'h08);
        rdc(8'hf1, 8'h08, "reenable");
        wr(8'hef, 8'h82);
        rdc(8'hf1, 8'h0a, "other");
        wr(8'hef, 8'h00);
        wr(8'hf1, 8'h08);
        tk(tok(3'd0, 4'b0010, 7'd0), 3'b100);
        rd(8'hed, v);
        chk("ep0 in", {7'h0, v[1]}, 8'h01);
        chk("ep0 out", endpoint0_status_out, 8'h02);
        wr(8'hec, 8'h02);
        chk("enable", {7'h0, usb_module_enable}, 8'h00);
        tk(tok(3'd0, 4'b0010, 7'd0), 3'b000);
        wr(8'hec, 8'h06);
        rd(8'hed, v);
        chk("ep0 flags", v & 8'h0b, 8'h00);
        wr(8'hef, 8'h82);
        rdc(8'hf1, 8'h08, "restart");
        tk(17'h00010, 3'b100);
        rdc(8'hed, 8'h04, "setup");
        win_base = {s, 8'h95};
        for (i = 0; i < 4; i = i + 1) begin
            s = $random(seed);
            wr(8'hef, {s[7], 6'h0, s[0]});
            @(negedge core_clk);
            xd_addr = {win_base[15:6], s[5:0]};
            xd_valid = 1'b1;
            @(negedge core_clk);
            xd_valid = 1'b0;
            chk("hit", {3'h0, win_hit, win_dir, win_ep},
                {3'h0, 1'b1, s[7], 2'b00, s[0]});
            chk("offset", {2'h0, win_offset}, {2'h0, s[5:0]});
        end
        xd_addr = win_base ^ 16'h4000;
        xd_valid = 1'b1;
        @(negedge core_clk);
        chk("miss", {7'h0, win_hit}, 8'h00);
        summarize;
    end
endmodule // tb_usb_endpoint_select_control
